// >>> hdl/ptm_condition.sv
// one terminal: polarity correction and previous-level capture
`timescale 1ns/100ps
module ptm_condition
   import ptm_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // terminal
   input  wire logic rawIn,
   input  wire logic polarity,
   // conditioned level
   output logic      level,
   output logic      levelPrev
);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         level     <= 1'b0;
         levelPrev <= 1'b0;
      end else begin
         level     <= rawIn ^ (polarity == POL_NC);
         levelPrev <= level;
      end
   end
endmodule

// >>> hdl/ptm_decode.sv
// one terminal: one-hot request decode of the assigned option code
`timescale 1ns/100ps
module ptm_decode
   import ptm_pkg::*;
(
   // terminal state
   input  wire logic [CODE_W-1:0] code,
   input  wire logic              level,
   input  wire logic              levelPrev,
   // per-function requests
   output logic                   rev,
   output logic [SPEED_W-1:0]     spd,
   output logic                   jog,
   output logic                   dcb,
   output logic                   mot2,
   output logic                   ramp2,
   output logic                   coast,
   output logic                   tripRise,
   output logic                   clr,
   output logic                   lockout,
   output logic                   anCur
);
   always_comb begin
      rev      = 1'b0;
      spd      = '0;
      jog      = 1'b0;
      dcb      = 1'b0;
      mot2     = 1'b0;
      ramp2    = 1'b0;
      coast    = 1'b0;
      tripRise = 1'b0;
      clr      = 1'b0;
      lockout  = 1'b0;
      anCur    = 1'b0;
      // undefined codes fall through and drive nothing
      case (code)
         OPT_REV:     rev      = level;
         OPT_SPD0:    spd[0]   = level;
         OPT_SPD1:    spd[1]   = level;
         OPT_SPD2:    spd[2]   = level;
         OPT_SPD3:    spd[3]   = level;
         OPT_JOG:     jog      = level;
         OPT_DCB:     dcb      = level;
         OPT_MOT2:    mot2     = level;
         OPT_RAMP2:   ramp2    = level;
         OPT_COAST:   coast    = level;
         OPT_EXTTRIP: tripRise = level & ~levelPrev;
         OPT_CLEAR:   clr      = level;
         OPT_LOCKOUT: lockout  = level;
         OPT_ANCUR:   anCur    = level;
         default: ;
      endcase
   end
endmodule

// >>> hdl/ptm_mapper.sv
// top: programmable input terminal mapper with APB register slave
`timescale 1ns/100ps
module ptm_mapper
   import ptm_pkg::*;
#(
   parameter bit ALT_VARIANT = 1'b0
)(
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // terminals
   input  wire logic [NUM_TERM-1:0]    terminalIn,
   input  wire logic                   forward_run_terminal,
   // control requests
   output logic                        forwardRunCommand,
   output logic                        backward_run_command,
   output logic [SPEED_W-1:0]          speedIndex,
   output logic                        jog_run_request,
   output logic                        dc_brake_request,
   output logic                        motorSetTwo,
   output logic                        alt_ramp_select,
   output logic                        coast_stop_request,
   output logic                        outside_fault_trip,
   output logic [TRIP_CODE_W-1:0]      tripCode,
   output logic                        trip_clear_input,
   output logic                        outputOff,
   output logic                        powerupResetReq,
   output logic                        powerup_restart_lockout,
   output logic                        analog_current_select
);
   logic [CODE_W-1:0]   selReg [NUM_TERM];
   logic [POL_W-1:0]    polReg;
   logic [NUM_TERM-1:0] level;
   logic [NUM_TERM-1:0] levelPrev;
   logic                fwdLevel;
   logic                condLive;
   logic [NUM_TERM-1:0] tRev, tJog, tDcb, tMot2, tRamp2, tCoast;
   logic [NUM_TERM-1:0] tTrip, tClr, tLock, tAnCur;
   logic [SPEED_W-1:0]  tSpd [NUM_TERM];
   logic [SPEED_W-1:0]  spdAll;
   logic                tripEvent;
   logic                clrAny;
   logic                lockoutSeen;
   logic                apbWrite;
   logic [31:0]         statusWord;
   logic [POL_W-1:0]    polNext;

   assign apbWrite = psel & penable & pwrite;

   // polarity write with the reset-option guard applied per terminal
   always_comb begin
      polNext = polReg;
      if (apbWrite && paddr == ADDR_POL)
         polNext = pwdata[POL_W-1:0];
      for (int i = 0; i < NUM_TERM; i++) begin
         if (selReg[i] == OPT_CLEAR)
            polNext[i] = POL_NO;
      end
   end

   // function select registers, reset to factory defaults
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         selReg[0] <= DEF_SEL1;
         selReg[1] <= DEF_SEL2;
         selReg[2] <= ALT_VARIANT ? DEF_SEL3_ALT : DEF_SEL3;
         selReg[3] <= DEF_SEL4;
         selReg[4] <= DEF_SEL5;
      end else if (apbWrite) begin
         unique case (paddr)
            ADDR_SEL1: selReg[0] <= pwdata[CODE_W-1:0];
            ADDR_SEL2: selReg[1] <= pwdata[CODE_W-1:0];
            ADDR_SEL3: selReg[2] <= pwdata[CODE_W-1:0];
            ADDR_SEL4: selReg[3] <= pwdata[CODE_W-1:0];
            ADDR_SEL5: selReg[4] <= pwdata[CODE_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         polReg <= {POL_W{POL_NO}};
         if (ALT_VARIANT)
            polReg[2] <= POL_NC;
      end else begin
         polReg <= polNext;
      end
   end

   // per-terminal conditioning and decode
   for (genvar g = 0; g < NUM_TERM; g++) begin : gTerm
      ptm_condition uCond (
         .sys_clk   (sys_clk),
         .rst_n     (rst_n),
         .rawIn     (terminalIn[g]),
         .polarity  (polReg[g]),
         .level     (level[g]),
         .levelPrev (levelPrev[g])
      );
      ptm_decode uDec (
         .code      (selReg[g]),
         .level     (level[g]),
         .levelPrev (levelPrev[g]),
         .rev       (tRev[g]),
         .spd       (tSpd[g]),
         .jog       (tJog[g]),
         .dcb       (tDcb[g]),
         .mot2      (tMot2[g]),
         .ramp2     (tRamp2[g]),
         .coast     (tCoast[g]),
         .tripRise  (tTrip[g]),
         .clr       (tClr[g]),
         .lockout   (tLock[g]),
         .anCur     (tAnCur[g])
      );
   end

   ptm_condition uFwd (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .rawIn     (forward_run_terminal),
      .polarity  (polReg[POL_FWD]),
      .level     (fwdLevel),
      .levelPrev ()
   );

   always_comb begin
      spdAll = '0;
      for (int i = 0; i < NUM_TERM; i++)
         spdAll = spdAll | tSpd[i];
   end

   assign tripEvent = |tTrip;
   assign clrAny    = |tClr;

   // request outputs, registered
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         forwardRunCommand     <= 1'b0;
         backward_run_command  <= 1'b0;
         speedIndex            <= '0;
         jog_run_request       <= 1'b0;
         dc_brake_request      <= 1'b0;
         motorSetTwo           <= 1'b0;
         alt_ramp_select       <= 1'b0;
         coast_stop_request    <= 1'b0;
         trip_clear_input      <= 1'b0;
         analog_current_select <= 1'b0;
      end else begin
         forwardRunCommand     <= fwdLevel;
         backward_run_command  <= |tRev;
         speedIndex            <= spdAll;
         jog_run_request       <= |tJog;
         dc_brake_request      <= |tDcb;
         motorSetTwo           <= |tMot2;
         alt_ramp_select       <= |tRamp2;
         coast_stop_request    <= |tCoast;
         trip_clear_input      <= clrAny;
         analog_current_select <= |tAnCur;
      end
   end

   // clear input forces output off and power-up reset while it is held
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         outputOff       <= 1'b0;
         powerupResetReq <= 1'b0;
      end else begin
         outputOff       <= clrAny | (|tCoast);
         powerupResetReq <= clrAny;
      end
   end

   // outside trip latch; a new edge wins over a clear in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         outside_fault_trip <= 1'b0;
         tripCode           <= TRIP_NONE;
      end else if (tripEvent) begin
         outside_fault_trip <= 1'b1;
         tripCode           <= TRIP_EXT;
      end else if (clrAny) begin
         outside_fault_trip <= 1'b0;
         tripCode           <= TRIP_NONE;
      end
   end

   // lockout level is captured once after reset, because only the
   // power-up state decides whether a run resumes; the reset values of
   // level and levelPrev agree, so a match counts only once the
   // terminals have been conditioned at least once
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         condLive                <= 1'b0;
         lockoutSeen             <= 1'b0;
         powerup_restart_lockout <= 1'b0;
      end else begin
         condLive <= 1'b1;
         if (condLive && !lockoutSeen && level == levelPrev) begin
            lockoutSeen             <= 1'b1;
            powerup_restart_lockout <= |tLock;
         end
      end
   end

   always_comb begin
      statusWord                  = '0;
      statusWord[ST_REV]          = backward_run_command;
      statusWord[ST_SPD +: SPEED_W] = speedIndex;
      statusWord[ST_JOG]          = jog_run_request;
      statusWord[ST_DCB]          = dc_brake_request;
      statusWord[ST_MOT2]         = motorSetTwo;
      statusWord[ST_RAMP2]        = alt_ramp_select;
      statusWord[ST_COAST]        = coast_stop_request;
      statusWord[ST_CLEAR]        = trip_clear_input;
      statusWord[ST_LOCKOUT]      = powerup_restart_lockout;
      statusWord[ST_ANCUR]        = analog_current_select;
      statusWord[ST_FWD]          = forwardRunCommand;
      statusWord[ST_TRIP]         = outside_fault_trip;
   end

   // apb: zero wait states, unmapped addresses answer slverr
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (psel && !penable) begin
            unique case (paddr)
               ADDR_SEL1:   prdata <= {26'h0, selReg[0]};
               ADDR_SEL2:   prdata <= {26'h0, selReg[1]};
               ADDR_SEL3:   prdata <= {26'h0, selReg[2]};
               ADDR_SEL4:   prdata <= {26'h0, selReg[3]};
               ADDR_SEL5:   prdata <= {26'h0, selReg[4]};
               ADDR_POL:    prdata <= {26'h0, polReg};
               ADDR_STATUS: prdata <= statusWord;
               ADDR_TRIP:   prdata <= {24'h0, tripCode};
               default:     pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule

// >>> hdl/ptm_pkg.sv
// package: option codes, defaults, register map of the terminal mapper
package ptm_pkg;
   localparam int          NUM_TERM     = 5;
   localparam int          CODE_W       = 6;
   localparam int          SPEED_W      = 4;
   localparam int          TRIP_CODE_W  = 8;
   // option codes
   localparam logic [5:0]  OPT_NONE     = 6'h00;
   localparam logic [5:0]  OPT_REV      = 6'h01;
   localparam logic [5:0]  OPT_SPD0     = 6'h02;
   localparam logic [5:0]  OPT_SPD1     = 6'h03;
   localparam logic [5:0]  OPT_SPD2     = 6'h04;
   localparam logic [5:0]  OPT_SPD3     = 6'h05;
   localparam logic [5:0]  OPT_JOG      = 6'h06;
   localparam logic [5:0]  OPT_DCB      = 6'h07;
   localparam logic [5:0]  OPT_MOT2     = 6'h08;
   localparam logic [5:0]  OPT_RAMP2    = 6'h09;
   localparam logic [5:0]  OPT_COAST    = 6'h0b;
   localparam logic [5:0]  OPT_EXTTRIP  = 6'h0c;
   localparam logic [5:0]  OPT_LOCKOUT  = 6'h0d;
   localparam logic [5:0]  OPT_ANCUR    = 6'h10;
   localparam logic [5:0]  OPT_CLEAR    = 6'h12;
   // polarity codes
   localparam logic        POL_NO       = 1'b0;
   localparam logic        POL_NC       = 1'b1;
   // trip code shown for an outside fault (E12)
   localparam logic [7:0]  TRIP_EXT     = 8'h0c;
   localparam logic [7:0]  TRIP_NONE    = 8'h00;
   // factory defaults
   localparam logic [5:0]  DEF_SEL1     = OPT_CLEAR;
   localparam logic [5:0]  DEF_SEL2     = OPT_ANCUR;
   localparam logic [5:0]  DEF_SEL3     = OPT_SPD1;
   localparam logic [5:0]  DEF_SEL3_ALT = OPT_LOCKOUT;
   localparam logic [5:0]  DEF_SEL4     = OPT_SPD0;
   localparam logic [5:0]  DEF_SEL5     = OPT_REV;
   // register byte offsets
   localparam logic [11:0] ADDR_SEL1    = 12'h000;
   localparam logic [11:0] ADDR_SEL2    = 12'h004;
   localparam logic [11:0] ADDR_SEL3    = 12'h008;
   localparam logic [11:0] ADDR_SEL4    = 12'h00c;
   localparam logic [11:0] ADDR_SEL5    = 12'h010;
   localparam logic [11:0] ADDR_POL     = 12'h014;
   localparam logic [11:0] ADDR_STATUS  = 12'h018;
   localparam logic [11:0] ADDR_TRIP    = 12'h01c;
   // status word bit positions; polarity register width and forward bit
   localparam int          ST_REV       = 0;
   localparam int          ST_SPD       = 1;
   localparam int          ST_JOG       = 5;
   localparam int          ST_DCB       = 6;
   localparam int          ST_MOT2      = 7;
   localparam int          ST_RAMP2     = 8;
   localparam int          ST_COAST     = 9;
   localparam int          ST_CLEAR     = 10;
   localparam int          ST_LOCKOUT   = 11;
   localparam int          ST_ANCUR     = 12;
   localparam int          ST_FWD       = 13;
   localparam int          ST_TRIP      = 14;
   localparam int          POL_W        = 6;
   localparam int          POL_FWD      = 5;
endpackage

// >>> testbench/ptm_mapper_sva.sv
// port-level assertions for the terminal mapper
`timescale 1ns/100ps
module ptm_mapper_chk
   import ptm_pkg::*;
(
   // clock and reset
   input wire logic                   sys_clk,
   input wire logic                   rst_n,
   // apb
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   // terminals and requests
   input wire logic [NUM_TERM-1:0]    terminalIn,
   input wire logic                   forward_run_terminal,
   input wire logic                   backward_run_command,
   input wire logic [SPEED_W-1:0]     speedIndex,
   input wire logic                   coast_stop_request,
   input wire logic                   trip_clear_input,
   input wire logic                   outputOff,
   input wire logic                   outside_fault_trip,
   input wire logic [TRIP_CODE_W-1:0] tripCode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire acc = psel & penable;

   access_ready_a: assert property ($rose(penable) && psel |-> pready)
      else $error("no ready in first access cycle");
   err_with_ready_a: assert property (pslverr |-> pready && acc)
      else $error("error response outside an answer");
   unmapped_err_a: assert property (acc && pready && paddr > ADDR_TRIP
      |-> pslverr) else $error("unmapped access not refused");
   mapped_ok_a: assert property (acc && pready && paddr <= ADDR_TRIP
      && paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped refused");
   off_cause_a: assert property (outputOff == (trip_clear_input
      || coast_stop_request)) else $error("output off mismatch");
   trip_code_a: assert property (tripCode ==
      (outside_fault_trip ? TRIP_EXT : TRIP_NONE))
      else $error("trip code mismatch");
   trip_hold_a: assert property ($fell(outside_fault_trip) |->
      trip_clear_input || $past(trip_clear_input)
      || $past(trip_clear_input, 2)) else $error("trip dropped");
   reset_clean_a: assert property ($rose(rst_n) |->
      !outside_fault_trip && !outputOff) else $error("dirty reset");
   quiet_stable_a: assert property ((!psel && $stable(terminalIn)
      && $stable(forward_run_terminal))[*4] |-> $stable(speedIndex)
      && $stable(backward_run_command) && $stable(outside_fault_trip))
      else $error("request moved without cause");
   trip_read_a: assert property (acc && pready && !pwrite
      && paddr == ADDR_TRIP && $stable(tripCode)
      |-> prdata == {24'h0, tripCode}) else $error("trip read wrong");

   cover property (outside_fault_trip ##[1:20] trip_clear_input);
   cover property (acc && pslverr);
   cover property (coast_stop_request && outputOff);
endmodule

bind ptm_mapper ptm_mapper_chk chk (.*);

// >>> testbench/ptm_switch_bank.sv
// switch bank model driving the terminal inputs
`timescale 1ns/100ps
module ptm_switch_bank
   import ptm_pkg::*;
(
   // clock
   input  wire logic                sys_clk,
   // contact commands
   input  wire logic [NUM_TERM-1:0] contactCmd,
   input  wire logic                fwdCmd,
   // terminal levels
   output logic      [NUM_TERM-1:0] terminalIn,
   output logic                     forward_run_terminal
);
   initial begin
      terminalIn = '0;
      forward_run_terminal = 1'b0;
   end
   // contacts only ever show a clean low or high, moved on an edge
   always @(posedge sys_clk) begin
      terminalIn <= contactCmd;
      forward_run_terminal <= fwdCmd;
   end
endmodule

// >>> testbench/tb_ptm_mapper.sv
// self-checking bench for the terminal mapper
`timescale 1ns/100ps
module tb_ptm_mapper;
   import ptm_pkg::*;
   logic        sys_clk    = 1'b0;
   logic        rst_n      = 1'b0;
   logic        psel       = 1'b0;
   logic        penable    = 1'b0;
   logic        pwrite     = 1'b0;
   logic [11:0] paddr      = '0;
   logic [31:0] pwdata     = '0;
   logic [4:0]  contactCmd = '0;
   logic        fwdCmd     = 1'b0;
   logic [31:0] prdata, rd, obsWord;
   logic [31:0] prdataAlt, rdAlt;
   logic        lockAlt;
   logic        pready, pslverr, err, fwdTerm;
   logic [4:0]  terminalIn;
   logic        fwdRun, revRun, jogReq, dcbReq, mot2, ramp2, coastReq;
   logic        tripFlag, clrReq, outOff, porReq, lockReq, anCur;
   logic [3:0]  spd;
   logic [7:0]  tripCode;
   int          n_fail     = 0;
   int          n_compared = 0;
   int          t;
   logic [5:0]  opt [12]   = '{OPT_REV, OPT_JOG, OPT_DCB, OPT_MOT2,
      OPT_RAMP2, OPT_COAST, OPT_ANCUR, OPT_SPD0, OPT_SPD1, OPT_SPD2,
      OPT_SPD3, OPT_CLEAR};
   int          stBit [12] = '{ST_REV, ST_JOG, ST_DCB, ST_MOT2, ST_RAMP2,
      ST_COAST, ST_ANCUR, ST_SPD, ST_SPD+1, ST_SPD+2, ST_SPD+3, ST_CLEAR};
   logic [5:0]  defSel [5] = '{6'h12, 6'h10, 6'h03, 6'h02, 6'h01};

   assign obsWord = {17'h0, tripFlag, fwdRun, anCur, lockReq, clrReq,
      coastReq, ramp2, mot2, dcbReq, jogReq, spd, revRun};

   initial begin
      forever #20 sys_clk = ~sys_clk;
   end

   ptm_switch_bank sw (.sys_clk(sys_clk), .contactCmd(contactCmd),
      .fwdCmd(fwdCmd), .terminalIn(terminalIn),
      .forward_run_terminal(fwdTerm));

   ptm_mapper dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .terminalIn(terminalIn), .forward_run_terminal(fwdTerm),
      .forwardRunCommand(fwdRun), .backward_run_command(revRun),
      .speedIndex(spd), .jog_run_request(jogReq),
      .dc_brake_request(dcbReq), .motorSetTwo(mot2),
      .alt_ramp_select(ramp2), .coast_stop_request(coastReq),
      .outside_fault_trip(tripFlag), .tripCode(tripCode),
      .trip_clear_input(clrReq), .outputOff(outOff),
      .powerupResetReq(porReq), .powerup_restart_lockout(lockReq),
      .analog_current_select(anCur));

   // variant build on the same bus: terminal three lockout, closed
   ptm_mapper #(.ALT_VARIANT(1'b1)) dutAlt (.sys_clk(sys_clk),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdataAlt), .pready(),
      .pslverr(), .terminalIn(terminalIn), .forward_run_terminal(fwdTerm),
      .forwardRunCommand(), .backward_run_command(), .speedIndex(),
      .jog_run_request(), .dc_brake_request(), .motorSetTwo(),
      .alt_ramp_select(), .coast_stop_request(), .outside_fault_trip(),
      .tripCode(), .trip_clear_input(), .outputOff(),
      .powerupResetReq(), .powerup_restart_lockout(lockAlt),
      .analog_current_select());

   task automatic tally_and_finish;
      $display("compared=%0d failed=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_fail++;
         tally_and_finish();
      end
      rd = prdata;
      rdAlt = prdataAlt;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk_word(rd, exp);
   endtask

   task automatic sel_wr(input int n, input logic [5:0] c);
      apb(1'b1, ADDR_SEL1 + 12'(4 * n), {26'h0, c});
   endtask

   // terminal path takes two edges; four leaves margin for the model
   task automatic drive(input logic [4:0] c, input logic f);
      @(posedge sys_clk);
      contactCmd <= c;
      fwdCmd <= f;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask

   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++)
         rd_chk(ADDR_SEL1 + 12'(4 * i), {26'h0, defSel[i]});
      rd_chk(ADDR_POL, 32'h0);
      chk_word(rdAlt, 32'h04);
      chk_word({31'h0, lockAlt}, 32'h1);
      apb(1'b0, ADDR_SEL3, 32'h0);
      chk_word(rdAlt, {26'h0, OPT_LOCKOUT});
      for (int i = 0; i < 5; i++)
         sel_wr(i, 6'h0a);
      drive(5'h1f, 1'b0);
      chk_word(obsWord, 32'h0);
      for (int i = 0; i < 12; i++) begin
         t = i % 5;
         sel_wr(t, opt[i]);
         drive(5'h01 << t, 1'b0);
         chk_word(obsWord, 32'h1 << stBit[i]);
         rd_chk(ADDR_STATUS, 32'h1 << stBit[i]);
         drive(5'h00, 1'b0);
         chk_word(obsWord, 32'h0);
         sel_wr(t, 6'h0a);
      end
      for (int i = 0; i < 5; i++)
         sel_wr(i, opt[7 + i % 4]);
      drive(5'h11, 1'b0);
      chk_word(obsWord, 32'h1 << ST_SPD);
      drive(5'h0a, 1'b0);
      chk_word(obsWord, 32'ha << ST_SPD);
      apb(1'b1, ADDR_POL, 32'h21);
      drive(5'h00, 1'b0);
      chk_word(obsWord, (32'h1 << ST_FWD) | (32'h1 << ST_SPD));
      rd_chk(ADDR_POL, 32'h21);
      apb(1'b1, ADDR_POL, 32'h0);
      drive(5'h00, 1'b1);
      chk_word(obsWord, 32'h1 << ST_FWD);
      sel_wr(0, OPT_CLEAR);
      apb(1'b1, ADDR_POL, 32'h01);
      rd_chk(ADDR_POL, 32'h0);
      sel_wr(0, 6'h0a);
      apb(1'b1, ADDR_POL, 32'h01);
      sel_wr(0, OPT_CLEAR);
      rd_chk(ADDR_POL, 32'h0);
      sel_wr(1, OPT_EXTTRIP);
      drive(5'h02, 1'b0);
      chk_word(obsWord, 32'h1 << ST_TRIP);
      rd_chk(ADDR_TRIP, {24'h0, TRIP_EXT});
      drive(5'h00, 1'b0);
      chk_word(obsWord, 32'h1 << ST_TRIP);
      drive(5'h01, 1'b0);
      chk_word(obsWord, 32'h1 << ST_CLEAR);
      chk_word({30'h0, outOff, porReq}, 32'h3);
      drive(5'h00, 1'b0);
      chk_word(obsWord, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk_word({31'h0, err}, 32'h1);
      apb(1'b1, ADDR_STATUS, 32'hffff);
      rd_chk(ADDR_STATUS, 32'h0);
      drive(5'h02, 1'b0);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd_chk(ADDR_SEL2, 32'h10);
      chk_word(obsWord, 32'h1 << ST_ANCUR);
      repeat (2) @(posedge sys_clk);
      #1;
      chk_word({31'h0, lockAlt}, 32'h1);
      tally_and_finish();
   end
endmodule
